// ==== core/gated_timer_pkg.sv ====
// Package: register map, field positions, reset values and counts of the gated timer
package gated_timer_pkg;
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CTL  = 8'h08;
  localparam logic [7:0] ADDR_GATE_CTL   = 8'h0c;
  localparam logic [7:0] ADDR_PERIPH_FLAG = 8'h10;
  localparam logic [7:0] ADDR_PERIPH_EN  = 8'h14;
  localparam logic [7:0] ADDR_INT_CTL    = 8'h18;

  localparam logic [7:0] TIMER_CTL_RESET = 8'h00;
  localparam logic [7:0] GATE_CTL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;

  // Flag / enable register bit positions
  localparam int GATE_EVENT_BIT = 7;
  localparam int OVERFLOW_BIT   = 0;
  localparam int GLOBAL_IE_BIT  = 7;
  localparam int PERIPH_IE_BIT  = 6;

  // Instruction clock is the system clock divided by this
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

  typedef enum logic [1:0] {
    CS_INSTR  = 2'b00,
    CS_SYSTEM = 2'b01,
    CS_EXT    = 2'b10,
    CS_LFOSC  = 2'b11
  } clock_source_t;

  typedef struct packed {
    clock_source_t clock_source_select;
    logic [1:0]    prescale_select;
    logic          unused3;
    logic          sync_bypass;
    logic          unused1;
    logic          timer_on;
  } timer_control_t;

  typedef struct packed {
    logic gate_enable;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
    logic acquisition_go;
    logic gate_value_status;
    logic unused1;
    logic gate_source_select;
  } gate_control_t;
endpackage : gated_timer_pkg

// ==== core/level_sync.sv ====
// Two-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module level_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : level_sync
`default_nettype wire

// ==== core/gated_timer.sv ====
// Gated 16-bit timer/counter with APB register access
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module gated_timer
  import gated_timer_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        gate_pin,
  input  wire logic        external_clock_pin,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        eight_bit_timer_wrap,
  input  wire logic        sleep,
  output logic             overflow_irq,
  output logic             gate_event_irq,
  output logic             wake
);
  timer_control_t ctl;
  gate_control_t  gctl;
  logic [15:0] count;
  logic [2:0]  prescale_count;
  logic [1:0]  instr_div;
  logic overflow_flag, gate_event_flag;
  logic overflow_irq_enable, gate_event_irq_enable;
  logic global_irq_enable, peripheral_irq_enable;
  logic ext_sync, ext_q, lf_q, fall_seen;
  logic src_q, toggle_ff, lvl_q, pulse_active, gate_value;

  // APB decode
  logic access, wr, rd_known;
  logic wr_low, wr_high, wr_count, wr_gate, wr_flag;
  logic [7:0] rd_byte;
  assign access   = psel & penable;
  assign wr       = access & pready & pwrite;
  assign wr_low   = wr & (paddr == ADDR_COUNT_LOW);
  assign wr_high  = wr & (paddr == ADDR_COUNT_HIGH);
  assign wr_count = wr_low | wr_high;
  assign wr_gate  = wr & (paddr == ADDR_GATE_CTL);
  assign wr_flag  = wr & (paddr == ADDR_PERIPH_FLAG);

  always_comb begin
    rd_known = 1'b1;
    rd_byte  = 8'h00;
    unique case (paddr)
      ADDR_COUNT_LOW:   rd_byte = count[7:0];
      ADDR_COUNT_HIGH:  rd_byte = count[15:8];
      ADDR_TIMER_CTL:   rd_byte = {ctl[7:4], 1'b0, ctl.sync_bypass, 1'b0, ctl.timer_on};
      ADDR_GATE_CTL:    rd_byte = {gctl[7:2], 1'b0, gctl.gate_source_select};
      ADDR_PERIPH_FLAG: rd_byte = {gate_event_flag, 6'h00, overflow_flag};
      ADDR_PERIPH_EN:   rd_byte = {gate_event_irq_enable, 6'h00, overflow_irq_enable};
      ADDR_INT_CTL:     rd_byte = {global_irq_enable, peripheral_irq_enable, 6'h00};
      default:          rd_known = 1'b0;
    endcase
  end

  // One wait state: read data is registered on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~rd_known;
      if (access & ~pready) begin
        prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl                   <= TIMER_CTL_RESET;
      overflow_irq_enable   <= 1'b0;
      gate_event_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
      peripheral_irq_enable <= 1'b0;
    end else if (wr) begin
      if (paddr == ADDR_TIMER_CTL) begin
        ctl <= timer_control_t'({pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]});
      end
      if (paddr == ADDR_PERIPH_EN) begin
        gate_event_irq_enable <= pwdata[GATE_EVENT_BIT];
        overflow_irq_enable   <= pwdata[OVERFLOW_BIT];
      end
      if (paddr == ADDR_INT_CTL) begin
        global_irq_enable     <= pwdata[GLOBAL_IE_BIT];
        peripheral_irq_enable <= pwdata[PERIPH_IE_BIT];
      end
    end
  end

  // Gate source, polarity, toggle and single pulse
  logic src, src_rise, lvl, lvl_rise, lvl_fall, pulse_hit, pulse_end, next_gate_value;
  assign src      = gctl.gate_source_select ? eight_bit_timer_wrap : gate_pin;
  assign src_rise = src & ~src_q;
  assign lvl      = (gctl.gate_toggle_mode ? toggle_ff : src) ~^ gctl.gate_polarity;
  assign lvl_rise = lvl & ~lvl_q;
  assign lvl_fall = ~lvl & lvl_q;
  assign pulse_hit = gctl.gate_single_pulse_mode & gctl.acquisition_go & lvl_rise;
  assign pulse_end = gctl.gate_single_pulse_mode & pulse_active & lvl_fall;
  assign next_gate_value = gctl.gate_single_pulse_mode ?
                           ((pulse_active | pulse_hit) & lvl & ~pulse_end) : lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      src_q <= src;
      lvl_q <= lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_ff <= 1'b0;
    end else if (!gctl.gate_toggle_mode || !ctl.timer_on) begin
      toggle_ff <= 1'b0;
    end else if (src_rise) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_active <= 1'b0;
    end else if (!gctl.gate_single_pulse_mode || pulse_end) begin
      pulse_active <= 1'b0;
    end else if (pulse_hit) begin
      pulse_active <= 1'b1;
    end
  end

  // Gate control register; software set of go wins over hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctl <= GATE_CTL_RESET;
    end else begin
      gctl.gate_value_status <= next_gate_value;
      if (wr_gate) begin
        gctl.gate_enable            <= pwdata[7];
        gctl.gate_polarity          <= pwdata[6];
        gctl.gate_toggle_mode       <= pwdata[5];
        gctl.gate_single_pulse_mode <= pwdata[4];
        gctl.acquisition_go         <= pwdata[3];
        gctl.gate_source_select     <= pwdata[0];
      end else if (pulse_end) begin
        gctl.acquisition_go <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_value <= 1'b0;
    end else begin
      gate_value <= next_gate_value;
    end
  end

  // Clock source selection
  level_sync u_ext_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (external_clock_pin),
    .dout    (ext_sync)
  );

  logic ext_src, ext_rise, ext_fall, lf_rise, instr_tick, src_tick;
  assign ext_src    = ctl.sync_bypass ? external_clock_pin : ext_sync;
  assign ext_rise   = ext_src & ~ext_q;
  assign ext_fall   = ~ext_src & ext_q;
  assign lf_rise    = low_freq_internal_osc & ~lf_q;
  assign instr_tick = (instr_div == INSTR_LAST);

  always_comb begin
    unique case (ctl.clock_source_select)
      CS_INSTR:  src_tick = instr_tick;
      CS_SYSTEM: src_tick = 1'b1;
      CS_EXT:    src_tick = ext_rise & fall_seen;
      CS_LFOSC:  src_tick = lf_rise;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q     <= 1'b0;
      lf_q      <= 1'b0;
      instr_div <= 2'h0;
    end else begin
      ext_q     <= ext_src;
      lf_q      <= low_freq_internal_osc;
      instr_div <= instr_div + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_seen <= 1'b0;
    end else if (wr_count || !ctl.timer_on) begin
      fall_seen <= 1'b0;
    end else if (ext_fall) begin
      fall_seen <= 1'b1;
    end
  end

  // Counting
  logic run, inc;
  logic [2:0] ps_last;
  assign run = ctl.timer_on & (~gctl.gate_enable | gate_value)
             & (~sleep | (ctl.sync_bypass & ctl.clock_source_select == CS_EXT));
  assign ps_last = 3'((4'h1 << ctl.prescale_select) - 4'h1);
  assign inc = run & src_tick & (prescale_count == ps_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 3'h0;
    end else if (wr_count) begin
      prescale_count <= 3'h0;
    end else if (run && src_tick) begin
      prescale_count <= (prescale_count == ps_last) ? 3'h0 : prescale_count + 3'h1;
    end
  end

  // Write collides with increment: the write wins, software should stop first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET;
    end else if (wr_low) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr_high) begin
      count[15:8] <= pwdata[7:0];
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag   <= 1'b0;
      gate_event_flag <= 1'b0;
    end else begin
      if (inc && count == COUNT_MAX) begin
        overflow_flag <= 1'b1;
      end else if (wr_flag) begin
        overflow_flag <= pwdata[OVERFLOW_BIT];
      end
      if (gate_value && !next_gate_value) begin
        gate_event_flag <= 1'b1;
      end else if (wr_flag) begin
        gate_event_flag <= pwdata[GATE_EVENT_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq   <= 1'b0;
      gate_event_irq <= 1'b0;
      wake           <= 1'b0;
    end else begin
      overflow_irq <= ctl.timer_on & overflow_flag & overflow_irq_enable
                    & peripheral_irq_enable & global_irq_enable;
      gate_event_irq <= gate_event_flag & gate_event_irq_enable
                      & peripheral_irq_enable & global_irq_enable;
      wake <= sleep & ctl.timer_on & overflow_flag & overflow_irq_enable
            & peripheral_irq_enable;
    end
  end

  // Checks
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (!run && !wr_count) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (inc && count == COUNT_MAX && !wr_count) |=> (count == 16'h0000) && overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap missing");

  property p_toggle_clear;
    @(posedge pclk) disable iff (!presetn)
      !gctl.gate_toggle_mode |=> !toggle_ff;
  endproperty
  a_toggle_clear: assert property (p_toggle_clear) else $error("toggle not clear");

  property p_toggle_off;
    @(posedge pclk) disable iff (!presetn)
      !ctl.timer_on |=> !toggle_ff;
  endproperty
  a_toggle_off: assert property (p_toggle_off) else $error("toggle set while off");

  property p_gate_event;
    @(posedge pclk) disable iff (!presetn)
      $fell(gate_value) |-> gate_event_flag;
  endproperty
  a_gate_event: assert property (p_gate_event) else $error("gate event lost");

  property p_prescale_clear;
    @(posedge pclk) disable iff (!presetn)
      wr_count |=> prescale_count == 3'h0;
  endproperty
  a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler kept");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      overflow_irq |-> $past(ctl.timer_on && overflow_flag && overflow_irq_enable
                             && peripheral_irq_enable && global_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enables");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      !gctl.gate_single_pulse_mode |=> gate_value == $past(lvl);
  endproperty
  a_polarity: assert property (p_polarity) else $error("gate level wrong");

  property p_go_clear;
    @(posedge pclk) disable iff (!presetn)
      (pulse_end && !wr_gate) |=> !gctl.acquisition_go ##1 !pulse_active;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go not cleared");

  property p_first_fall;
    @(posedge pclk) disable iff (!presetn)
      (ctl.clock_source_select == CS_EXT && !fall_seen) |-> !inc;
  endproperty
  a_first_fall: assert property (p_first_fall) else $error("counted before fall");
endmodule : gated_timer
`default_nettype wire

// ==== tb/timer_partner.sv ====
// Model of the gate pin, external clock, oscillator and eight-bit timer wrap
`timescale 1ns/1ns
`default_nettype none
module timer_partner (
  input  wire logic pclk,
  input  wire logic ext_en,
  input  wire logic wrap_en,
  output logic      gate_pin,
  output logic      ext_clk,
  output logic      lf_osc,
  output logic      wrap
);
  logic [3:0] tick;

  initial begin
    gate_pin = 1'b0;
    ext_clk = 1'b0;
    lf_osc = 1'b0;
    wrap = 1'b0;
    tick = 4'h0;
  end

  // Oscillator runs free; external clock stands still unless enabled
  always @(posedge pclk) begin
    tick <= tick + 4'h1;
    lf_osc <= tick[3];
    wrap <= wrap_en && tick == 4'hf;
    if (ext_en && tick[1:0] == 2'h3) begin
      ext_clk <= !ext_clk;
    end
  end

  task automatic set_gate(input logic v);
    @(posedge pclk);
    gate_pin <= v;
  endtask : set_gate

  task automatic set_ext(input logic v);
    @(posedge pclk);
    ext_clk <= v;
  endtask : set_ext
endmodule : timer_partner
`default_nettype wire

// ==== tb/gated_timer_tb.sv ====
// Self-checking bench for the gated timer
`timescale 1ns/1ns
`default_nettype none
module gated_timer_tb;
  import gated_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep;
  logic        ext_en, wrap_en, gate_pin, ext_clk, lf_osc, wrap, err;
  logic        overflow_irq, gate_event_irq, wake;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata;
  int          num_errors, checks;

  gated_timer u_gated_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .gate_pin(gate_pin),
    .external_clock_pin(ext_clk), .low_freq_internal_osc(lf_osc),
    .eight_bit_timer_wrap(wrap), .sleep(sleep), .overflow_irq(overflow_irq),
    .gate_event_irq(gate_event_irq), .wake(wake));
  timer_partner u_timer_partner (.pclk(pclk), .ext_en(ext_en), .wrap_en(wrap_en),
    .gate_pin(gate_pin), .ext_clk(ext_clk), .lf_osc(lf_osc), .wrap(wrap));

  always #5 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] v);
    checks++;
    if (v !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask : cmp

  // One APB transfer; holds the request until pready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    logic late;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    late = (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (late) begin
      num_errors++;
      $display("mismatch pready expected 1 seen 0");
      end_sim();
    end
  endtask : bus

  task automatic chk(input string s, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp(s, {8'h00, e}, {8'h00, q & m});
  endtask : chk

  // Reads both count bytes and accepts a window around the expected count
  task automatic near(input string s, input int e, input int t);
    logic [15:0] v;
    bus(1'b0, ADDR_COUNT_LOW, 8'h00);
    v[7:0] = q;
    bus(1'b0, ADDR_COUNT_HIGH, 8'h00);
    v[15:8] = q;
    checks++;
    if ($isunknown(v) || int'(v) > e + t || int'(v) + t < e) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", s, e, v);
    end
  endtask : near

  task automatic clr();
    bus(1'b1, ADDR_COUNT_LOW, 8'h00);
    bus(1'b1, ADDR_COUNT_HIGH, 8'h00);
  endtask : clr

  // Counts for n+4 cycles from a cleared count, then stops
  task automatic run(input logic [7:0] ctl, input int n);
    clr();
    bus(1'b1, ADDR_TIMER_CTL, ctl);
    repeat (n) @(posedge pclk);
    bus(1'b1, ADDR_TIMER_CTL, ctl & 8'hfe);
  endtask : run

  function automatic int per(input logic [1:0] c);
    return c == 2'd0 ? INSTR_DIV : c == 2'd1 ? 1 : 8 << (c - 2'd2);
  endfunction : per

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    sleep = 1'b0;
    ext_en = 1'b0;
    wrap_en = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("timer_control", ADDR_TIMER_CTL, 8'hff, TIMER_CTL_RESET);
    chk("gate_control", ADDR_GATE_CTL, 8'hfb, GATE_CTL_RESET);
    bus(1'b0, 8'h1c, 8'h00);
    cmp("pslverr", 16'h1, {15'h0, err});
    ext_en <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      run({i[3:0], 4'h1}, 480);
      near("source count", 484 / (per(i[3:2]) << i[1:0]), 2);
    end
    for (int i = 0; i < 4; i++) begin
      u_timer_partner.set_gate(i[0]);
      bus(1'b1, ADDR_GATE_CTL, {1'b1, i[1], 6'h00});
      run(8'h41, 40);
      near("gated count", i[0] == i[1] ? 44 : 0, 2);
    end
    u_timer_partner.set_gate(1'b1);
    wrap_en <= 1'b1;
    bus(1'b1, ADDR_GATE_CTL, 8'hc1);
    run(8'h41, 480);
    near("wrap gated count", 30, 3);
    wrap_en <= 1'b0;
    bus(1'b1, ADDR_GATE_CTL, 8'h40);
    bus(1'b1, ADDR_PERIPH_FLAG, 8'h00);
    bus(1'b1, ADDR_PERIPH_EN, 8'h80);
    bus(1'b1, ADDR_INT_CTL, 8'hc0);
    chk("gate value", ADDR_GATE_CTL, 8'h04, 8'h04);
    u_timer_partner.set_gate(1'b0);
    repeat (4) @(posedge pclk);
    chk("gate value", ADDR_GATE_CTL, 8'h04, 8'h00);
    chk("gate flag", ADDR_PERIPH_FLAG, 8'h80, 8'h80);
    cmp("gate irq", 16'h1, {15'h0, gate_event_irq});
    bus(1'b1, ADDR_COUNT_LOW, 8'hfe);
    bus(1'b1, ADDR_COUNT_HIGH, 8'hff);
    bus(1'b1, ADDR_TIMER_CTL, 8'h41);
    bus(1'b1, ADDR_TIMER_CTL, 8'h40);
    chk("overflow flag", ADDR_PERIPH_FLAG, 8'h01, 8'h01);
    near("wrapped count", 2, 2);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ADDR_TIMER_CTL, {7'h70, i != 1});
      bus(1'b1, ADDR_PERIPH_EN, {7'h00, i != 2});
      bus(1'b1, ADDR_INT_CTL, {i != 4, i != 3, 6'h00});
      repeat (2) @(posedge pclk);
      cmp("overflow irq", {15'h0, i == 0}, {15'h0, overflow_irq});
    end
    bus(1'b1, ADDR_TIMER_CTL, 8'h00);
    bus(1'b1, ADDR_GATE_CTL, 8'hd0);
    bus(1'b1, ADDR_GATE_CTL, 8'hd8);
    clr();
    bus(1'b1, ADDR_TIMER_CTL, 8'h41);
    for (int k = 0; k < 2; k++) begin
      u_timer_partner.set_gate(1'b1);
      repeat (20) @(posedge pclk);
      u_timer_partner.set_gate(1'b0);
      repeat (4) @(posedge pclk);
      chk("go bit", ADDR_GATE_CTL, 8'h08, 8'h00);
    end
    bus(1'b1, ADDR_TIMER_CTL, 8'h40);
    near("single pulse count", 21, 2);
    bus(1'b1, ADDR_GATE_CTL, 8'h40);
    bus(1'b1, ADDR_GATE_CTL, 8'he0);
    clr();
    bus(1'b1, ADDR_TIMER_CTL, 8'h41);
    for (int k = 0; k < 2; k++) begin
      u_timer_partner.set_gate(1'b1);
      u_timer_partner.set_gate(1'b0);
      repeat (30) @(posedge pclk);
    end
    bus(1'b1, ADDR_TIMER_CTL, 8'h40);
    near("toggle count", 32, 3);
    ext_en <= 1'b0;
    bus(1'b1, ADDR_GATE_CTL, 8'h00);
    u_timer_partner.set_ext(1'b0);
    clr();
    bus(1'b1, ADDR_TIMER_CTL, 8'h81);
    for (int k = 0; k < 3; k++) begin
      u_timer_partner.set_ext(k[0]);
      repeat (6) @(posedge pclk);
      u_timer_partner.set_ext(1'b1);
      repeat (6) @(posedge pclk);
      near("external edge count", k / 2, 0);
    end
    bus(1'b1, ADDR_TIMER_CTL, 8'h80);
    bus(1'b1, ADDR_COUNT_LOW, 8'hf0);
    bus(1'b1, ADDR_COUNT_HIGH, 8'hff);
    bus(1'b1, ADDR_PERIPH_FLAG, 8'h00);
    bus(1'b1, ADDR_PERIPH_EN, 8'h01);
    bus(1'b1, ADDR_INT_CTL, 8'h40);
    bus(1'b1, ADDR_TIMER_CTL, 8'h85);
    cmp("wake", 16'h0, {15'h0, wake});
    sleep <= 1'b1;
    ext_en <= 1'b1;
    for (int k = 0; k < 400 && wake !== 1'b1; k++) begin
      @(posedge pclk);
    end
    cmp("wake", 16'h1, {15'h0, wake});
    end_sim();
  end
endmodule : gated_timer_tb
`default_nettype wire
